// File: include/gpp_cfg.svh
// Offsets, field positions and reset values of the general-purpose pin port
`ifndef GPP_CFG_SVH
`define GPP_CFG_SVH

// ==========================================================
// Register byte offsets from the port base
`define GPP_OFS_VALUE 17'h1_0000
`define GPP_OFS_DIR 17'h1_0008
`define GPP_OFS_CFG 17'h1_0010
`define GPP_OFS_FLAGS 17'h1_0014
`define GPP_OFS_MASK 17'h1_0018

// ==========================================================
// Field positions
`define GPP_EVT_PINS 7
`define GPP_EVT_BASE 25
`define GPP_EN_LSB 0
`define GPP_ACT_LSB 8
`define GPP_TRIG_LSB 16
`define GPP_FLAG_LSB 16

// ==========================================================
// Writable bits and reset values
`define GPP_CFG_WMASK 32'h007F_7F7F
`define GPP_FLAG_WMASK 32'h007F_0000
`define GPP_RST_VALUE 32'h0000_0000
`define GPP_RST_DIR 32'h0000_0000
`define GPP_RST_CFG 32'h0000_0000
`define GPP_RST_MASK 32'h0000_0000

`endif

// File: include/gpp_pkg.sv
// Types shared by the general-purpose pin port
package gpp_pkg;

    // ==========================================================
    // Bus answer states, one-hot
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h1,
        ST_ACK = 2'h2
    } gpp_state_t;

endpackage

// File: rtl/gpp_evt.sv
// One event-capable pin: edge or level detect with a sticky flag
`timescale 1ns/1ps
`include "gpp_cfg.svh"

module gpp_evt
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Pin and its setup
    input wire logic pin_lvl_in,
    input wire logic use_in,
    input wire logic level_mode_in,
    input wire logic act_high_in,
    // Software clear
    input wire logic clear_in,
    // Results
    output logic hit_out,
    output logic flag_out
);

    logic prev_ff;
    logic armed_ff;
    logic flag_ff;
    logic act_lvl;
    logic edge_seen;

    // ==========================================================
    // Detection
    // Armed only after one sample, so reset cannot fake an edge
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            prev_ff <= 1'b0;
            armed_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= pin_lvl_in;
            armed_ff <= 1'b1;
        end
    end

    // Sense and trigger select
    assign act_lvl = act_high_in ? pin_lvl_in : !pin_lvl_in; // R6
    assign edge_seen = armed_ff && act_lvl && (prev_ff != pin_lvl_in); // R6
    assign hit_out = use_in && (level_mode_in ? act_lvl : edge_seen); // R5 R12

    // Sticky flag; a new event beats a clear in the same cycle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            flag_ff <= 1'b0;
        else if (hit_out)
            flag_ff <= 1'b1; // R7 R12
        else if (clear_in)
            flag_ff <= 1'b0; // R8
    end

    assign flag_out = flag_ff;

    // ==========================================================
    // Checks
    a_level_refire: // R12
        assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
            (use_in && level_mode_in && act_lvl) |=> flag_ff)
        else $error("active level did not hold flag set");

endmodule

// File: rtl/gpp_port.sv
// General-purpose pin port: Wishbone registers, pin drive and event flags
`timescale 1ns/1ps
`include "gpp_cfg.svh"

// ==========================================================
// How it works
// (R1) Input pins are sampled into value register
// (R2) Output pins drive the value register bits
// (R3) Direction register: one means output, reset input
// (R4) Setup bits 6:0 make upper pins event inputs
// (R5) Setup bits 22:16 pick edge or level
// (R6) Setup bits 14:8 pick low/fall or high/rise
// (R7) Events set sticky flags in bits 22:16
// (R8) Writing ones to clear address drops flags
// (R9) Flags offset reads status, writes clear
// (R10) Registers sit at fixed offsets from base
// (R11) Host keeps away from reserved test offsets
// (R12) Unused pins never flag; levels refire
module gpp_port
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // Wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [16:0] wb_adr_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    // Pins
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe_n_out,
    // Interrupt
    output logic irq_out
);

    // ==========================================================
    // Declarations
    gpp_pkg::gpp_state_t state_ff;
    gpp_pkg::gpp_state_t nxt_state;
    logic [31:0] value_ff;
    logic [31:0] nxt_value;
    logic [31:0] dir_ff;
    logic [31:0] cfg_ff;
    logic [31:0] mask_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] wr_bmask;
    logic [31:0] wr_merge_val;
    logic [31:0] eff_dir;
    logic [16:0] adr_al;
    logic req_new;
    logic wr_go;
    logic hit_val;
    logic hit_dir;
    logic hit_cfg;
    logic hit_flags;
    logic hit_mask;
    logic [6:0] cfg_en;
    logic [6:0] cfg_act;
    logic [6:0] cfg_trig;
    logic [6:0] clr_bits;
    logic [6:0] evt_hit;
    logic [6:0] flags;
    logic [6:0] mask_bits;

    // ==========================================================
    // Address decode
    // Offsets are kept relative to the port, so the base can move
    assign adr_al = {wb_adr_in[16:2], 2'h0}; // R10
    assign hit_val = adr_al == `GPP_OFS_VALUE; // R10
    assign hit_dir = adr_al == `GPP_OFS_DIR; // R3
    assign hit_cfg = adr_al == `GPP_OFS_CFG;
    assign hit_flags = adr_al == `GPP_OFS_FLAGS; // R9
    assign hit_mask = adr_al == `GPP_OFS_MASK;

    // Byte lanes from the select lines
    assign wr_bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                       {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

    // ==========================================================
    // Bus handshake
    // A request is seen in idle; its write lands at the acking edge
    assign req_new = wb_cyc_in && wb_stb_in && (state_ff == gpp_pkg::ST_IDLE);
    assign wr_go = wb_cyc_in && wb_stb_in && wb_we_in && (state_ff == gpp_pkg::ST_ACK);
    assign wb_ack_out = state_ff == gpp_pkg::ST_ACK;

    // Next state
    always_comb
    begin
        nxt_state = gpp_pkg::ST_IDLE;
        unique case (state_ff)
            gpp_pkg::ST_IDLE:
            begin
                if (wb_cyc_in && wb_stb_in)
                    nxt_state = gpp_pkg::ST_ACK;
            end
            gpp_pkg::ST_ACK:
                nxt_state = gpp_pkg::ST_IDLE;
            default:
                nxt_state = gpp_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            state_ff <= gpp_pkg::ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // ==========================================================
    // Read path
    // Unmapped and reserved offsets read as zero and still ack
    always_comb
    begin
        nxt_rdata = 32'h0000_0000; // R11
        if (hit_val)
            nxt_rdata = value_ff; // R1
        else if (hit_dir)
            nxt_rdata = dir_ff;
        else if (hit_cfg)
            nxt_rdata = cfg_ff;
        else if (hit_flags)
            nxt_rdata = 32'(flags) << `GPP_FLAG_LSB; // R9
        else if (hit_mask)
            nxt_rdata = mask_ff;
    end

    // Read data is caught when the request is first seen
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            rdata_ff <= 32'h0000_0000;
        else if (req_new && !wb_we_in)
            rdata_ff <= nxt_rdata;
    end

    assign wb_dat_out = rdata_ff;

    // ==========================================================
    // Direction register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            dir_ff <= `GPP_RST_DIR; // R3
        else if (wr_go && hit_dir)
            dir_ff <= (dir_ff & ~wr_bmask) | (wb_dat_in & wr_bmask); // R3
    end

    // Event pins are always inputs while in event use
    assign eff_dir = dir_ff & ~{cfg_en, 25'h000_0000}; // R4

    // ==========================================================
    // Pin value register
    // A written input bit is overwritten by the pin on the same edge
    assign wr_merge_val = (value_ff & ~wr_bmask) | (wb_dat_in & wr_bmask);

    always_comb
    begin
        nxt_value = value_ff;
        if (wr_go && hit_val)
            nxt_value = wr_merge_val; // R2
        nxt_value = (nxt_value & eff_dir) | (pin_in & ~eff_dir); // R1
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            value_ff <= `GPP_RST_VALUE;
        else
            value_ff <= nxt_value;
    end

    // Drive side; enable is low while the pin is driven
    assign pin_out = value_ff; // R2
    assign pin_oe_n_out = ~eff_dir; // R2 R3

    // ==========================================================
    // Event setup register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            cfg_ff <= `GPP_RST_CFG;
        else if (wr_go && hit_cfg)
            cfg_ff <= ((cfg_ff & ~wr_bmask) | (wb_dat_in & wr_bmask)) & `GPP_CFG_WMASK;
    end

    // Field split
    assign cfg_en = cfg_ff[`GPP_EN_LSB +: `GPP_EVT_PINS]; // R4
    assign cfg_act = cfg_ff[`GPP_ACT_LSB +: `GPP_EVT_PINS]; // R6
    assign cfg_trig = cfg_ff[`GPP_TRIG_LSB +: `GPP_EVT_PINS]; // R5

    // ==========================================================
    // Interrupt mask register, same layout as the flags
    always_ff @(posedge clk_sys_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            mask_ff <= `GPP_RST_MASK;
        else if (wr_go && hit_mask)
            mask_ff <= ((mask_ff & ~wr_bmask) | (wb_dat_in & wr_bmask)) & `GPP_FLAG_WMASK;
    end

    assign mask_bits = mask_ff[`GPP_FLAG_LSB +: `GPP_EVT_PINS];

    // Clear strobes: ones written to the flags offset, zeros no-op
    assign clr_bits = (wr_go && hit_flags)
        ? (wb_dat_in[`GPP_FLAG_LSB +: `GPP_EVT_PINS]
           & wr_bmask[`GPP_FLAG_LSB +: `GPP_EVT_PINS])
        : 7'h00; // R8 R9

    // ==========================================================
    // Event detectors, one per event-capable pin
    for (genvar i = 0; i < `GPP_EVT_PINS; i++)
    begin : g_evt
        gpp_evt u_evt
        (
            .clk_sys_in(clk_sys_in),
            .sys_rst_in(sys_rst_in),
            .pin_lvl_in(pin_in[`GPP_EVT_BASE + i]),
            .use_in(cfg_en[i]),
            .level_mode_in(cfg_trig[i]),
            .act_high_in(cfg_act[i]),
            .clear_in(clr_bits[i]),
            .hit_out(evt_hit[i]),
            .flag_out(flags[i])
        );
    end

    // Level interrupt: any unmasked flag holds it high
    assign irq_out = |(flags & mask_bits); // R7

    // ==========================================================
    // Checks
    default clocking dcb @(posedge clk_sys_in);
    endclocking
    default disable iff (sys_rst_in);

    a_in_capture: // R1
        assert property (!(wr_go && hit_val)
            |=> ((value_ff ^ $past(pin_in)) & ~$past(eff_dir)) == 32'h0000_0000)
        else $error("input pin level not captured");

    a_out_drive: // R2
        assert property ((wr_go && hit_val && wb_sel_in == 4'hF)
            |=> ((pin_out ^ $past(wb_dat_in)) & $past(eff_dir)) == 32'h0000_0000)
        else $error("output pin not driven from written value");

    a_dir_write: // R3
        assert property ((wr_go && hit_dir && wb_sel_in == 4'hF)
            |=> pin_oe_n_out[24:0] == ~$past(wb_dat_in[24:0]))
        else $error("direction write not applied to pin enable");

    a_evt_input: // R4
        assert property ((pin_oe_n_out[31:25] | ~cfg_en) == 7'h7F)
        else $error("event pin driven while in event use");

    a_flag_sticky: // R7
        assert property (clr_bits == 7'h00 |=> ($past(flags) & ~flags) == 7'h00)
        else $error("flag dropped without a clear");

    a_flag_clear: // R8
        assert property (clr_bits != 7'h00
            |=> (flags & $past(clr_bits) & ~$past(evt_hit)) == 7'h00)
        else $error("flag not cleared by write of one");

    a_flag_read: // R9
        assert property ((req_new && !wb_we_in && hit_flags)
            ##1 wb_ack_out |-> wb_dat_out == (32'($past(flags)) << 16))
        else $error("flags read back wrong");

    a_unused_quiet: // R12
        assert property ((flags & ~$past(flags) & ~$past(cfg_en)) == 7'h00)
        else $error("flag set on pin not in event use");

    a_ack_single: // R10
        assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held beyond one cycle");

    a_irq_mask: // R7
        assert property ((flags & mask_bits) == 7'h00 |-> !irq_out)
        else $error("interrupt raised with nothing unmasked");

    // Bus answer and read data
    a_ack_answer: // R10
        assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
        else $error("request not answered one cycle later");

    a_read_value: // R1
        assert property ((req_new && !wb_we_in && hit_val)
            |=> wb_dat_out == $past(value_ff))
        else $error("value register read back wrong");

    // Read data must stand until the next read is taken
    a_rdata_hold: // R9
        assert property (!(req_new && !wb_we_in) |=> $stable(wb_dat_out))
        else $error("read data changed without a read");

    // Register writes land whole and hold otherwise
    a_cfg_write: // R5
        assert property ((wr_go && hit_cfg && wb_sel_in == 4'hF)
            |=> cfg_ff == ($past(wb_dat_in) & `GPP_CFG_WMASK))
        else $error("setup write not applied");

    a_mask_write: // R7
        assert property ((wr_go && hit_mask && wb_sel_in == 4'hF)
            |=> mask_ff == ($past(wb_dat_in) & `GPP_FLAG_WMASK))
        else $error("mask write not applied");

    a_dir_hold: // R3
        assert property (!(wr_go && hit_dir) |=> $stable(dir_ff))
        else $error("direction changed without a write");

    a_val_hold: // R2
        assert property (!(wr_go && hit_val)
            |=> ((value_ff ^ $past(value_ff)) & $past(eff_dir)) == 32'h0000_0000)
        else $error("output bit changed without a write");

    // Set beats clear, and a masked-in set raises the line next cycle
    a_flag_set: // R7
        assert property (evt_hit != 7'h00
            |=> (flags & $past(evt_hit)) == $past(evt_hit))
        else $error("event did not set its flag");

    a_irq_follow: // R7
        assert property (((evt_hit & mask_bits) != 7'h00 && !(wr_go && hit_mask))
            |=> irq_out)
        else $error("unmasked event did not raise interrupt");

    // Scenarios the bench must reach
    c_flag_set:
        cover property ($rose(|flags));
    c_flag_clear:
        cover property (clr_bits != 7'h00 ##1 flags == 7'h00);
    c_irq_rise:
        cover property ($rose(irq_out));
    c_pin_drive:
        cover property (wr_go && hit_dir ##1 pin_oe_n_out != 32'hFFFF_FFFF);
    c_level_keep:
        cover property ((clr_bits & flags & cfg_trig & cfg_en) != 7'h00 ##1 flags != 7'h00);

endmodule

// File: test/gpp_pin_model.sv
// Outside devices on the port's pins, resolved against the port's own drive
`timescale 1ns/1ps

module gpp_pin_model
(
    // Port drive
    input wire logic [31:0] drv_in,
    input wire logic [31:0] drv_oe_n_in,
    // Levels the outside devices want
    input wire logic [31:0] ext_in,
    // Resolved pin levels
    output logic [31:0] lvl_out
);
    // Driven pin follows the port, released pin follows its device
    assign lvl_out = (drv_in & ~drv_oe_n_in) | (ext_in & drv_oe_n_in);
endmodule

// File: test/tb_top.sv
// Self-checking bench for the general-purpose pin port
`timescale 1ns/1ps
`include "gpp_cfg.svh"

`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            err_count++; \
            $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
        end \
    end

module tb_top;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] sel = 4'hF;
    logic [16:0] adr = 17'h0_0000;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] ext = 32'h0000_0000;
    logic [31:0] dat_rd;
    logic ack;
    logic [31:0] pin_drv;
    logic [31:0] pin_oe_n;
    logic [31:0] pin_lvl;
    logic irq;
    logic [31:0] rd;
    logic [31:0] m_dir;
    logic [31:0] m_val;
    logic [31:0] m_mask;
    logic [31:0] m_cfg;
    logic [31:0] bit_k;
    logic lvl;
    logic act;
    logic [16:0] ofs [5];
    int unsigned m_reg [int];
    int unsigned m_wmask [int];
    int err_count = 0;
    int n_tests = 0;

    gpp_port i_dut
    (
        .clk_sys_in(clk_sys),
        .sys_rst_in(sys_rst),
        .wb_cyc_in(cyc),
        .wb_stb_in(stb),
        .wb_we_in(we),
        .wb_sel_in(sel),
        .wb_adr_in(adr),
        .wb_dat_in(dat),
        .wb_dat_out(dat_rd),
        .wb_ack_out(ack),
        .pin_in(pin_lvl),
        .pin_out(pin_drv),
        .pin_oe_n_out(pin_oe_n),
        .irq_out(irq)
    );

    gpp_pin_model i_pins
    (
        .drv_in(pin_drv),
        .drv_oe_n_in(pin_oe_n),
        .ext_in(ext),
        .lvl_out(pin_lvl)
    );

    // ==========================================================
    // Clock, closing and hang guard
    initial
    begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is a few hundred cycles, so this only cuts a hang
    initial
    begin
        #200000;
        err_count++;
        give_verdict();
    end

    // Reset image of the plain registers; the unmapped place reads zero
    task automatic model_reset();
        m_reg[int'(`GPP_OFS_DIR)] = `GPP_RST_DIR;
        m_reg[int'(`GPP_OFS_CFG)] = `GPP_RST_CFG;
        m_reg[int'(`GPP_OFS_MASK)] = `GPP_RST_MASK;
        m_reg[int'(17'h1_0004)] = 32'h0000_0000;
    endtask

    // One classic Wishbone cycle; no latency assumed, the watchdog ends a hang
    task automatic bus(input logic [16:0] a, input logic w, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] q);
        logic [31:0] wm;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_sys);
        end
        while (ack !== 1'b1);
        q = dat_rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        // Model of the plain registers: lane merge on write, compare on read
        wm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (m_reg.exists(int'(a)))
        begin
            if (w)
                m_reg[int'(a)] = ((m_reg[int'(a)] & ~wm) | (d & wm)) & m_wmask[int'(a)];
            else
                `CHK(q, m_reg[int'(a)])
        end
    endtask

    // ==========================================================
    // Scenarios
    initial
    begin
        void'($urandom(79));
        m_wmask[int'(`GPP_OFS_DIR)] = 32'hFFFF_FFFF;
        m_wmask[int'(`GPP_OFS_CFG)] = `GPP_CFG_WMASK;
        m_wmask[int'(`GPP_OFS_MASK)] = `GPP_FLAG_WMASK;
        m_wmask[int'(17'h1_0004)] = 32'h0000_0000;
        model_reset();
        ofs = '{`GPP_OFS_VALUE, `GPP_OFS_DIR, `GPP_OFS_CFG, `GPP_OFS_FLAGS, `GPP_OFS_MASK};
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Reset contents and all pins released
        foreach (ofs[i])
        begin
            bus(ofs[i], 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, 32'h0000_0000)
        end
        `CHK(pin_oe_n, 32'hFFFF_FFFF)
        // Mixed directions against random outside levels
        ext <= $urandom();
        m_dir = $urandom();
        m_val = $urandom();
        bus(`GPP_OFS_DIR, 1'b1, m_dir, 4'hF, rd);
        bus(`GPP_OFS_VALUE, 1'b1, m_val, 4'hF, rd);
        bus(`GPP_OFS_VALUE, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, (m_val & m_dir) | (ext & ~m_dir))
        `CHK(pin_drv & m_dir, m_val & m_dir)
        `CHK(pin_oe_n, ~m_dir)
        bus(`GPP_OFS_DIR, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, m_dir)
        // Byte lane then full word into setup; reserved bits stay zero
        bus(`GPP_OFS_CFG, 1'b1, 32'hFFFF_FFFF, 4'h1, rd);
        bus(`GPP_OFS_CFG, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, 32'h0000_007F)
        bus(`GPP_OFS_CFG, 1'b1, 32'hFFFF_FFFF, 4'hF, rd);
        bus(`GPP_OFS_CFG, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, 32'h007F_7F7F)
        // Active levels present but event use off: nothing may flag
        ext <= 32'hFE00_0000;
        bus(`GPP_OFS_CFG, 1'b1, 32'h007F_7F00, 4'hF, rd);
        bus(`GPP_OFS_FLAGS, 1'b1, 32'h007F_0000, 4'hF, rd);
        bus(`GPP_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, 32'h0000_0000)
        // Each event pin with random trigger, sense and mask
        for (int k = 0; k < 7; k++)
        begin
            lvl = 1'($urandom_range(1));
            act = 1'($urandom_range(1));
            m_mask = {9'h000, 7'($urandom()), 16'h0000};
            bit_k = 32'h0000_0001 << (16 + k);
            m_cfg = ({31'h0, lvl} << (16 + k)) | ({31'h0, act} << (8 + k));
            m_cfg = m_cfg | (32'h0000_0001 << k);
            ext[25 + k] <= ~act;
            bus(`GPP_OFS_MASK, 1'b1, m_mask, 4'hF, rd);
            bus(`GPP_OFS_MASK, 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, m_mask)
            bus(`GPP_OFS_CFG, 1'b1, m_cfg, 4'hF, rd);
            bus(`GPP_OFS_FLAGS, 1'b1, 32'h007F_0000, 4'hF, rd);
            bus(`GPP_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, 32'h0000_0000)
            ext[25 + k] <= act;
            // Zeros written to the clear place change nothing
            bus(`GPP_OFS_FLAGS, 1'b1, 32'h0000_0000, 4'hF, rd);
            bus(`GPP_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, bit_k)
            `CHK(irq, |(bit_k & m_mask))
            bus(`GPP_OFS_FLAGS, 1'b1, bit_k, 4'hF, rd);
            bus(`GPP_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, lvl ? bit_k : 32'h0000_0000)
            ext[25 + k] <= ~act;
            bus(`GPP_OFS_FLAGS, 1'b1, bit_k, 4'hF, rd);
            bus(`GPP_OFS_FLAGS, 1'b0, 32'h0000_0000, 4'hF, rd);
            `CHK(rd, 32'h0000_0000)
            `CHK(irq, 1'b0)
        end
        // Reset in mid-run: direction register and pin drive back to reset state
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        model_reset();
        `CHK(pin_oe_n, 32'hFFFF_FFFF)
        bus(`GPP_OFS_DIR, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, `GPP_RST_DIR)
        // Unmapped place, kept clear of the reserved test span
        bus(17'h1_0004, 1'b1, 32'hFFFF_FFFF, 4'hF, rd);
        bus(17'h1_0004, 1'b0, 32'h0000_0000, 4'hF, rd);
        `CHK(rd, 32'h0000_0000)
        give_verdict();
    end
endmodule
